//--- hdl/fcfr_consts.svh
// Purpose: Opcodes, bit positions and reset values of the flash config/flag registers.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef FCFR_CONSTS_SVH
`define FCFR_CONSTS_SVH

// ****************************************************************
// Serial command codes
// ****************************************************************
`define FCFR_OP_WR_EN        8'h06
`define FCFR_OP_WR_DIS       8'h04
`define FCFR_OP_RD_FLAGS     8'h70
`define FCFR_OP_CLR_FLAGS    8'h50
`define FCFR_OP_RD_CFG       8'h65
`define FCFR_OP_WR_CFG       8'h61

// ****************************************************************
// Volatile protocol configuration fields
// ****************************************************************
`define FCFR_CFG_QUAD_BIT    7
`define FCFR_CFG_DUAL_BIT    6
`define FCFR_CFG_RSVD_BIT    5
`define FCFR_CFG_HOLD_BIT    4
`define FCFR_CFG_VPP_BIT     3
`define FCFR_CFG_DRV_MSB     2
`define FCFR_CFG_DRV_LSB     0
`define FCFR_CFG_RESET       8'hdf
`define FCFR_CFG_RSVD_VAL    1'b0
`define FCFR_DRV_RSVD_A      3'h0
`define FCFR_DRV_RSVD_B      3'h4

// ****************************************************************
// Flag status fields
// ****************************************************************
`define FCFR_FLG_READY_BIT   7
`define FCFR_FLG_ESUSP_BIT   6
`define FCFR_FLG_EERR_BIT    5
`define FCFR_FLG_PERR_BIT    4
`define FCFR_FLG_VPP_BIT     3
`define FCFR_FLG_PSUSP_BIT   2
`define FCFR_FLG_PROT_BIT    1
`define FCFR_FLG_RSVD_VAL    1'b0
`define FCFR_BITS_PER_BYTE   4'h8

`endif

//--- hdl/fcfr_core.sv
// Purpose: Serial-link side of the flash volatile configuration and flag status
//          registers: frame decoder, configuration register and read-out.
// Assumes: ref_clk_i is many times faster than the serial clock; link pins are
//          asynchronous and are synchronised before use; serial mode 0.
// Notes:   Other commands are skipped until chip select rises.
//
// Functional notes
// - Config bit 7 low selects four-line protocol; high default is single-line.
// - Config bit 6 low selects two-line protocol; high default is single-line.
// - Both bits low gives four-line protocol; four-line wins over two-line.
// - Protocol change takes effect when the configuration write completes.
// - Config bit 4 high enables hold/reset pin function; default high.
// - Config bit 3 low enables high-voltage acceleration for quad programs.
// - Bits 2:0 choose driver impedance; 111 default, 000 and 100 reserved.
// - Configuration readable and writable in single, two and four-line protocols.
// - Flag bit 7 low while a program or erase cycle runs.
// - Flag bit 6 high while erase suspended or suspend pending.
// - Flag bit 5 set on erase failure or protection refusal.
// - Flag bit 4 set on program failure, protection, or 0-to-1 attempt.
// - Flag bit 3 set on invalid program supply voltage.
// - Flag bit 2 high while program suspended or suspend pending.
// - Flag bit 1 set on protected sector or locked OTP target.
// - All flag bits are volatile; read by the flag read command.
// - Busy and suspend bits clear by themselves when the condition ends.
// - Error bits hold until the clear command, which zeroes them.
// - Flag read is 70h, clear is 50h; no address, no dummy.
`timescale 1ns/1ps
`include "fcfr_consts.svh"
module fcfr_core (
   input  wire logic               ref_clk_i,        // Core clock, 250 MHz.
   input  wire logic               resetn_i,         // Synchronous reset, active low.
   input  wire logic               sclk_i,           // Serial clock pin.
   input  wire logic               cs_n_i,           // Chip select pin, active low.
   input  wire logic [3:0]         dq_i,             // Data pins, input side.
   output logic      [3:0]         dq_o,             // Data pins, output side.
   output logic      [3:0]         dq_oe_o,          // Data pin drive enables.
   input  wire logic               busy_i,           // Array cycle in progress.
   input  wire logic               erase_susp_i,     // Erase suspend in effect.
   input  wire logic               prog_susp_i,      // Program suspend in effect.
   input  wire logic               erase_err_i,      // Pulse: erase error.
   input  wire logic               prog_err_i,       // Pulse: program error.
   input  wire logic               vpp_err_i,        // Pulse: supply error.
   input  wire logic               prot_err_i,       // Pulse: protection error.
   output fcfr_pkg::fcfr_mode_e    protocol_mode_o,  // Active line protocol.
   output logic                    hold_reset_en_o,  // Hold/reset pin function on.
   output logic                    vpp_accel_en_o,   // High-voltage acceleration on.
   output logic      [2:0]         drv_strength_o,   // Driver impedance code.
   output logic                    wel_o,            // Write enable latch.
   output logic      [7:0]         flags_o           // Flag status byte.
);
   import fcfr_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Lines used per serial clock edge in each protocol.
   function automatic logic [3:0] fcfr_lanes(input fcfr_mode_e m);
      case (m)
         FCFR_QUAD: fcfr_lanes = 4'h4;
         FCFR_DUAL: fcfr_lanes = 4'h2;
         default:   fcfr_lanes = 4'h1;
      endcase
   endfunction

   // Protocol implied by a configuration byte.
   function automatic fcfr_mode_e fcfr_decode(input logic [7:0] c);
      if (!c[`FCFR_CFG_QUAD_BIT]) begin
         fcfr_decode = FCFR_QUAD;
      end else if (!c[`FCFR_CFG_DUAL_BIT]) begin
         fcfr_decode = FCFR_DUAL;
      end else begin
         fcfr_decode = FCFR_EXT;
      end
   endfunction

   // Shift received lines into a byte, most significant first.
   function automatic logic [7:0] fcfr_shift_in(input logic [7:0] r, input logic [3:0] d,
                                                 input fcfr_mode_e m);
      case (m)
         FCFR_QUAD: fcfr_shift_in = {r[3:0], d[3:0]};
         FCFR_DUAL: fcfr_shift_in = {r[5:0], d[1:0]};
         default:   fcfr_shift_in = {r[6:0], d[0]};
      endcase
   endfunction

   // ****************************************************************
   // Pin synchronisation and flag register
   // ****************************************************************

   logic [5:0] pins_s;
   logic       sclk_s;
   logic       cs_n_s;
   logic [3:0] dq_s;
   logic [7:0] flags_w;

   // Chip select reads as deselected while in reset.
   fcfr_sync #(
      .WIDTH (6)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .async_i   ({sclk_i, cs_n_i, dq_i}),
      .rst_val_i (6'h10),
      .sync_o    (pins_s)
   );

   assign sclk_s = pins_s[5];
   assign cs_n_s = pins_s[4];
   assign dq_s   = pins_s[3:0];

   fcfr_core_s s_q, s_d;

   fcfr_flags u_flags (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .busy_i       (busy_i),
      .erase_susp_i (erase_susp_i),
      .prog_susp_i  (prog_susp_i),
      .erase_err_i  (erase_err_i),
      .prog_err_i   (prog_err_i),
      .vpp_err_i    (vpp_err_i),
      .prot_err_i   (prot_err_i),
      .clear_i      (s_q.clr),
      .flags_o      (flags_w)
   );

   // ****************************************************************
   // Read-back values
   // ****************************************************************

   logic [7:0] cfg_rd;
   logic [7:0] rd_val;

   always_comb begin
      cfg_rd                     = s_q.cfg;
      cfg_rd[`FCFR_CFG_RSVD_BIT] = `FCFR_CFG_RSVD_VAL;
   end

   assign rd_val = (s_q.opc == `FCFR_OP_RD_FLAGS) ? flags_w : cfg_rd;

   // ****************************************************************
   // Frame decoder
   // ****************************************************************

   logic       rise;
   logic       fall;
   logic [3:0] lanes;
   logic [7:0] rx_nx;
   logic [3:0] cnt_nx;
   logic [7:0] cfg_nx;

   assign rise   = sclk_s & ~s_q.sclk_prev;
   assign fall   = ~sclk_s & s_q.sclk_prev;
   assign lanes  = fcfr_lanes(s_q.mode);
   assign rx_nx  = fcfr_shift_in(s_q.rx, dq_s, s_q.mode);
   assign cnt_nx = s_q.cnt + lanes;

   // Incoming configuration byte; a reserved impedance code keeps the old one,
   // so the pads never see an undefined driver setting.
   always_comb begin
      cfg_nx = s_q.rx;
      cfg_nx[`FCFR_CFG_RSVD_BIT] = `FCFR_CFG_RSVD_VAL;
      if (s_q.rx[2:0] == `FCFR_DRV_RSVD_A || s_q.rx[2:0] == `FCFR_DRV_RSVD_B) begin
         cfg_nx[`FCFR_CFG_DRV_MSB:`FCFR_CFG_DRV_LSB] = s_q.cfg[2:0];
      end
   end

   // Commands act at chip select rise, so a frame cut short does nothing.
   always_comb begin
      s_d           = s_q;
      s_d.sclk_prev = sclk_s;
      s_d.clr       = 1'b0;
      if (cs_n_s) begin
         case (s_q.phase)
            FCFR_P_DONE: begin
               case (s_q.opc)
                  `FCFR_OP_WR_EN:     s_d.wel = 1'b1;
                  `FCFR_OP_WR_DIS:    s_d.wel = 1'b0;
                  `FCFR_OP_CLR_FLAGS: s_d.clr = 1'b1;
                  default:            s_d.wel = s_q.wel;
               endcase
            end
            FCFR_P_WFULL: begin
               if (s_q.wel) begin
                  s_d.cfg  = cfg_nx;
                  s_d.mode = fcfr_decode(cfg_nx);
                  s_d.wel  = 1'b0;
               end
            end
            default: begin
               s_d.wel = s_q.wel;
            end
         endcase
         s_d.phase = FCFR_P_IDLE;
         s_d.cnt   = 4'h0;
         s_d.dq_oe = 4'h0;
      end else if (rise) begin
         case (s_q.phase)
            FCFR_P_IDLE, FCFR_P_OPC: begin
               s_d.rx    = rx_nx;
               s_d.cnt   = cnt_nx;
               s_d.phase = FCFR_P_OPC;
               if (cnt_nx == `FCFR_BITS_PER_BYTE) begin
                  s_d.opc = rx_nx;
                  s_d.cnt = 4'h0;
                  case (rx_nx)
                     `FCFR_OP_RD_FLAGS, `FCFR_OP_RD_CFG: begin
                        s_d.phase = FCFR_P_READ;
                        s_d.tx    = (rx_nx == `FCFR_OP_RD_FLAGS) ? flags_w : cfg_rd;
                     end
                     `FCFR_OP_WR_CFG: s_d.phase = FCFR_P_WDATA;
                     `FCFR_OP_WR_EN, `FCFR_OP_WR_DIS, `FCFR_OP_CLR_FLAGS: begin
                        s_d.phase = FCFR_P_DONE;
                     end
                     default: s_d.phase = FCFR_P_SKIP;
                  endcase
               end
            end
            FCFR_P_WDATA: begin
               s_d.rx  = rx_nx;
               s_d.cnt = cnt_nx;
               if (cnt_nx == `FCFR_BITS_PER_BYTE) begin
                  s_d.phase = FCFR_P_WFULL;
               end
            end
            // Extra clocks after a complete command abandon it.
            FCFR_P_DONE, FCFR_P_WFULL: s_d.phase = FCFR_P_SKIP;
            default:                   s_d.phase = s_q.phase;
         endcase
      end else if (fall && s_q.phase == FCFR_P_READ) begin
         // Data changes on the falling edge so it is stable at the host's rising edge.
         case (s_q.mode)
            FCFR_QUAD: begin
               s_d.dq    = s_q.tx[7:4];
               s_d.dq_oe = 4'hf;
            end
            FCFR_DUAL: begin
               s_d.dq    = {2'h0, s_q.tx[7:6]};
               s_d.dq_oe = 4'h3;
            end
            default: begin
               s_d.dq    = {2'h0, s_q.tx[7], 1'b0};
               s_d.dq_oe = 4'h2;
            end
         endcase
         s_d.tx  = s_q.tx << lanes;
         s_d.cnt = cnt_nx;
         // Reading repeats; each byte is a fresh snapshot of the register.
         if (cnt_nx == `FCFR_BITS_PER_BYTE) begin
            s_d.tx  = rd_val;
            s_d.cnt = 4'h0;
         end
      end
   end

   // All decoder state in one register.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_q           <= '0;
         s_q.phase     <= FCFR_P_IDLE;
         s_q.mode      <= FCFR_EXT;
         s_q.cfg       <= `FCFR_CFG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign protocol_mode_o = s_q.mode;
   assign hold_reset_en_o = s_q.cfg[`FCFR_CFG_HOLD_BIT];
   assign vpp_accel_en_o  = ~s_q.cfg[`FCFR_CFG_VPP_BIT];
   assign drv_strength_o  = s_q.cfg[`FCFR_CFG_DRV_MSB:`FCFR_CFG_DRV_LSB];
   assign wel_o           = s_q.wel;
   assign flags_o         = flags_w;
   assign dq_o            = s_q.dq;
   assign dq_oe_o         = s_q.dq_oe;

endmodule

//--- hdl/fcfr_flags.sv
// Purpose: Flag status byte: live status bits and sticky error bits.
// Assumes: Status levels and error pulses come from array logic on ref_clk_i.
// Notes:   An error pulse in the cycle of a clear leaves the bit set.
`timescale 1ns/1ps
`include "fcfr_consts.svh"
module fcfr_flags (
   input  wire logic       ref_clk_i,     // Core clock.
   input  wire logic       resetn_i,      // Synchronous reset, active low.
   input  wire logic       busy_i,        // Program/erase/register write cycle running.
   input  wire logic       erase_susp_i,  // Erase suspended or suspend pending.
   input  wire logic       prog_susp_i,   // Program suspended or suspend pending.
   input  wire logic       erase_err_i,   // Pulse: erase failed or refused.
   input  wire logic       prog_err_i,    // Pulse: program failed, refused, or 0-to-1 at high VPP.
   input  wire logic       vpp_err_i,     // Pulse: bad program supply during an operation.
   input  wire logic       prot_err_i,    // Pulse: protected sector or locked OTP targeted.
   input  wire logic       clear_i,       // Pulse: clear command executed.
   output logic      [7:0] flags_o        // Flag status byte, registered.
);
   import fcfr_pkg::*;

   fcfr_flags_s s_q, s_d;

   // Status bits follow their conditions; error bits hold until cleared.
   always_comb begin
      s_d = s_q;
      s_d.ready = ~busy_i;
      s_d.esusp = erase_susp_i;
      s_d.psusp = prog_susp_i;
      if (clear_i) begin
         s_d.eerr = 1'b0;
         s_d.perr = 1'b0;
         s_d.vpp  = 1'b0;
         s_d.prot = 1'b0;
      end
      if (erase_err_i) begin
         s_d.eerr = 1'b1;
      end
      if (prog_err_i) begin
         s_d.perr = 1'b1;
      end
      if (vpp_err_i) begin
         s_d.vpp = 1'b1;
      end
      if (prot_err_i) begin
         s_d.prot = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_q <= '{ready: 1'b1, default: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Reserved bit 0 is fixed; the error sources never reach it.
   always_comb begin
      flags_o                       = 8'h00;
      flags_o[`FCFR_FLG_READY_BIT]  = s_q.ready;
      flags_o[`FCFR_FLG_ESUSP_BIT]  = s_q.esusp;
      flags_o[`FCFR_FLG_EERR_BIT]   = s_q.eerr;
      flags_o[`FCFR_FLG_PERR_BIT]   = s_q.perr;
      flags_o[`FCFR_FLG_VPP_BIT]    = s_q.vpp;
      flags_o[`FCFR_FLG_PSUSP_BIT]  = s_q.psusp;
      flags_o[`FCFR_FLG_PROT_BIT]   = s_q.prot;
      flags_o[0]                    = `FCFR_FLG_RSVD_VAL;
   end

endmodule

//--- hdl/fcfr_pkg.sv
// Purpose: Types shared by the flash config/flag register block.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only; numbers live in the header.
package fcfr_pkg;

   // Line protocol selected by the configuration register.
   typedef enum logic [1:0] {FCFR_EXT, FCFR_DUAL, FCFR_QUAD} fcfr_mode_e;

   // Position of the serial frame decoder.
   typedef enum logic [2:0] {
      FCFR_P_IDLE, FCFR_P_OPC, FCFR_P_DONE, FCFR_P_WDATA, FCFR_P_WFULL, FCFR_P_READ, FCFR_P_SKIP
   } fcfr_phase_e;

   // Whole state of the frame decoder and configuration register.
   typedef struct packed {
      fcfr_phase_e phase;
      fcfr_mode_e  mode;
      logic [3:0]  cnt;
      logic [7:0]  rx;
      logic [7:0]  opc;
      logic [7:0]  tx;
      logic [7:0]  cfg;
      logic        wel;
      logic        sclk_prev;
      logic        clr;
      logic [3:0]  dq;
      logic [3:0]  dq_oe;
   } fcfr_core_s;

   // Sticky error bits and sampled status levels of the flag register.
   typedef struct packed {
      logic ready;
      logic esusp;
      logic psusp;
      logic eerr;
      logic perr;
      logic vpp;
      logic prot;
   } fcfr_flags_s;

endpackage

//--- hdl/fcfr_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are levels that stay put for several clock periods.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module fcfr_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             ref_clk_i,  // Core clock.
   input  wire logic             resetn_i,   // Synchronous reset, active low.
   input  wire logic [WIDTH-1:0] async_i,    // Raw pin levels.
   input  wire logic [WIDTH-1:0] rst_val_i,  // Level shown while in reset.
   output logic      [WIDTH-1:0] sync_o      // Synchronised levels.
);

   // Refuse a width that leaves nothing to synchronise.
   if (WIDTH < 1) begin : g_chk
      $error("fcfr_sync WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } fcfr_sync_s;

   fcfr_sync_s s_q, s_d;

   // Stage one feeds stage two only.
   always_comb begin
      s_d    = s_q;
      s_d.s1 = async_i;
      s_d.s2 = s_q.s1;
   end

   // The reset value is a port, so it is loaded as data, not as a reset constant.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_q.s1 <= rst_val_i;
         s_q.s2 <= rst_val_i;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.s2;

endmodule

//--- test/fcfr_core_sva.sv
// Purpose: Port checks of the config/flag register block.
// Assumes: Chip select idles high outside frames.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module fcfr_core_sva (
   input  wire logic           ref_clk_i,       // Core clock.
   input  wire logic           resetn_i,        // Reset, active low.
   input  wire logic           cs_n_i,          // Chip select.
   input  wire logic           busy_i,          // Array busy.
   input  wire logic           erase_susp_i,    // Erase suspend.
   input  wire logic           erase_err_i,     // Erase error.
   input  wire logic           prog_err_i,      // Program error.
   input  wire logic           vpp_err_i,       // Supply error.
   input  wire logic           prot_err_i,      // Protection error.
   input  wire logic [3:0]     dq_oe_o,         // Drive enables.
   input  fcfr_pkg::fcfr_mode_e protocol_mode_o, // Protocol.
   input  wire logic [7:0]     flags_o          // Flag byte.
);
   import fcfr_pkg::*;
   logic [3:0] low_q = 4'h0;
   logic [3:0] high_q = 4'h0;
   // ****************************************************************
   // Chip select age, saturating so long frames do not wrap.
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      low_q  <= cs_n_i ? 4'h0 : (low_q == 4'hf ? low_q : low_q + 4'h1);
      high_q <= !cs_n_i ? 4'h0 : (high_q == 4'hf ? high_q : high_q + 4'h1);
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   a_busy_low: assert property (busy_i |=> !flags_o[7])
      else $error("ready bit high while busy");
   a_ready_back: assert property (!busy_i |=> flags_o[7])
      else $error("ready bit stuck low");
   a_esusp_shown: assert property (erase_susp_i |=> flags_o[6])
      else $error("erase suspend bit missing");
   a_eerr_set: assert property (erase_err_i |=> flags_o[5])
      else $error("erase error bit not set");
   a_perr_set: assert property (prog_err_i |=> flags_o[4])
      else $error("program error bit not set");
   a_vpp_set: assert property (vpp_err_i |=> flags_o[3])
      else $error("supply error bit not set");
   a_prot_set: assert property (prot_err_i |=> flags_o[1])
      else $error("protection bit not set");
   a_err_sticky: assert property (flags_o[4] && low_q > 4'h5 |=> flags_o[4])
      else $error("error bit dropped inside a frame");
   a_oe_lines: assert property (dq_oe_o != 4'h0 |-> dq_oe_o ==
      (protocol_mode_o == FCFR_QUAD ? 4'hf : (protocol_mode_o == FCFR_DUAL ? 4'h3 : 4'h2)))
      else $error("drive enables do not match protocol");
   a_oe_idle: assert property (high_q > 4'h5 |-> dq_oe_o == 4'h0)
      else $error("data driven while deselected");
endmodule

//--- test/fcfr_core_tb.sv
// Purpose: Self-checking bench of the config/flag register block.
// Assumes: Host model drives the link; array status comes from here.
// Notes:   Each scenario is its own task.
`timescale 1ns/1ps
module fcfr_core_tb;
   import fcfr_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic       sclk;
   logic       cs_n;
   logic [3:0] dq_i;
   logic [3:0] dq_o;
   logic [3:0] dq_oe;
   logic       busy = 1'b0;
   logic       esus = 1'b0;
   logic       psus = 1'b0;
   logic [3:0] err = 4'h0;
   fcfr_mode_e mode;
   logic       hold;
   logic       accel;
   logic [2:0] drv;
   logic       wel;
   logic [7:0] flags;
   logic [7:0] rd;
   int         errors = 0;
   int         checks = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   fcfr_host fcfr_host_i (.ref_clk_i(ref_clk_i), .dq_o(dq_o), .dq_oe_o(dq_oe),
      .sclk_o(sclk), .cs_n_o(cs_n), .dq_i(dq_i));
   fcfr_core fcfr_core_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe), .busy_i(busy),
      .erase_susp_i(esus), .prog_susp_i(psus), .erase_err_i(err[0]), .prog_err_i(err[1]),
      .vpp_err_i(err[2]), .prot_err_i(err[3]), .protocol_mode_o(mode),
      .hold_reset_en_o(hold), .vpp_accel_en_o(accel), .drv_strength_o(drv),
      .wel_o(wel), .flags_o(flags));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic int lines(input fcfr_mode_e m);
      return m == FCFR_QUAD ? 4 : (m == FCFR_DUAL ? 2 : 1);
   endfunction
   // ****************************************************************
   // Configuration scenarios; outputs settle well within the tail.
   // ****************************************************************
   task automatic chk_cfg(input logic [7:0] c);
      fcfr_mode_e m;
      m = !c[7] ? FCFR_QUAD : (!c[6] ? FCFR_DUAL : FCFR_EXT);
      check(8'(mode), 8'(m)); // protocol
      check({3'h0, hold, accel, drv}, {3'h0, c[4], ~c[3], c[2:0]}); // fields
      fcfr_host_i.xfer(lines(m), 8'h65, 0, 8'h00, 8, rd);
      check(rd, c); // readback
   endtask
   task automatic wcfg(input logic [7:0] v);
      fcfr_host_i.xfer(lines(mode), 8'h06, 0, 8'h00, 0, rd); // latch first
      check(8'(wel), 8'h01); // latch set
      fcfr_host_i.xfer(lines(mode), 8'h61, 8, v, 0, rd);
      check(8'(wel), 8'h00); // latch used up
   endtask
   task automatic t_wel;
      fcfr_host_i.xfer(1, 8'h06, 0, 8'h00, 0, rd);
      fcfr_host_i.xfer(1, 8'h04, 0, 8'h00, 0, rd);
      check(8'(wel), 8'h00); // latch dropped
      fcfr_host_i.xfer(1, 8'h61, 8, 8'h00, 0, rd); // write without latch
      chk_cfg(8'hdf); // config kept
   endtask
   task automatic t_cfg_modes;
      logic [7:0] wv [4] = '{8'hbf, 8'h22, 8'h7c, 8'hdf};
      logic [7:0] ev [4] = '{8'h9f, 8'h02, 8'h5a, 8'hdf};
      fcfr_host_i.xfer(1, 8'h61, 8, 8'h00, 0, rd);
      chk_cfg(8'hdf); // ignored write
      for (int i = 0; i < 4; i++) begin
         wcfg(wv[i]);
         chk_cfg(ev[i]); // each protocol
      end
   endtask
   task automatic t_drv_codes;
      logic [2:0] prev;
      prev = 3'h7;
      for (int c = 0; c < 8; c++) begin
         wcfg(8'hd8 | 8'(c));
         prev = (c == 0 || c == 4) ? prev : 3'(c);
         chk_cfg(8'hd8 | 8'(prev)); // impedance codes
      end
   endtask
   // ****************************************************************
   // Flag scenarios.
   // ****************************************************************
   task automatic t_status;
      @(negedge ref_clk_i) {busy, esus, psus} = 3'h7;
      fcfr_host_i.xfer(1, 8'h70, 0, 8'h00, 8, rd);
      check(rd, 8'h44); // live status
      @(negedge ref_clk_i) {busy, esus, psus} = 3'h0;
      repeat (2) @(negedge ref_clk_i);
      check(flags, 8'h80); // clears alone
   endtask
   task automatic t_errors;
      logic [7:0] eb [4] = '{8'h20, 8'h10, 8'h08, 8'h02};
      for (int k = 0; k < 4; k++) begin
         @(negedge ref_clk_i) err[k] = 1'b1;
         @(negedge ref_clk_i) err[k] = 1'b0;
         repeat (20) @(negedge ref_clk_i);
         check(flags, 8'h80 | eb[k]); // set
         fcfr_host_i.xfer(1, 8'h70, 0, 8'h00, 8, rd);
         check(rd, 8'h80 | eb[k]); // sticky read
         fcfr_host_i.xfer(1, 8'h50, 0, 8'h00, 0, rd); // clear before more
         check(flags, 8'h80); // cleared
      end
   endtask
   initial begin
      repeat (10) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      check(flags, 8'h80); // after reset
      chk_cfg(8'hdf); // defaults
      t_cfg_modes();
      t_drv_codes();
      t_wel();
      t_status();
      t_errors();
      finish_test();
   end
   initial begin
      #200000;
      errors++;
      finish_test();
   end
endmodule
bind fcfr_core fcfr_core_sva fcfr_core_sva_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
   .cs_n_i(cs_n_i), .busy_i(busy_i), .erase_susp_i(erase_susp_i), .erase_err_i(erase_err_i),
   .prog_err_i(prog_err_i), .vpp_err_i(vpp_err_i), .prot_err_i(prot_err_i),
   .dq_oe_o(dq_oe_o), .protocol_mode_o(protocol_mode_o), .flags_o(flags_o));

//--- test/fcfr_host.sv
// Purpose: Host serial controller model in mode 0.
// Assumes: Driven on the falling core clock edge, link half period 40 ns.
// Notes:   Released lines show the inverse of their last level.
`timescale 1ns/1ps
module fcfr_host (
   input  wire logic       ref_clk_i, // Core clock, paces the link.
   input  wire logic [3:0] dq_o,      // Device data out.
   input  wire logic [3:0] dq_oe_o,   // Device drive enables.
   output logic            sclk_o,    // Serial clock, idle low.
   output logic            cs_n_o,    // Chip select, active low.
   output logic      [3:0] dq_i       // Resolved data lines.
);
   logic [3:0] drv = 4'h0;
   logic [3:0] hoe = 4'h0;
   logic [3:0] last_q = 4'h0;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
   end
   // Wire level from both parties; a floating line keeps toggling.
   always_ff @(posedge ref_clk_i) last_q <= dq_i;
   assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & hoe & drv) | (~dq_oe_o & ~hoe & ~last_q);
   task automatic half;
      repeat (10) @(negedge ref_clk_i);
   endtask
   // Opcode then data only, no address.
   task automatic xfer(input int n, input logic [7:0] op, input int wb,
                       input logic [7:0] wd, input int rb, output logic [7:0] rd);
      logic [15:0] sh;
      logic [3:0]  m;
      sh = {op, wd};
      m = 4'((1 << n) - 1);
      rd = 8'h00;
      cs_n_o = 1'b0;
      hoe = m;
      for (int i = 0; i < (8 + wb) / n; i++) begin
         drv = 4'(sh[15 -: 4] >> (4 - n));
         sh = sh << n;
         half();
         sclk_o = 1'b1;
         half();
         sclk_o = 1'b0;
      end
      hoe = 4'h0;
      for (int i = 0; i < rb / n; i++) begin
         half();
         // The single-line answer comes back on line 1, not on the command line 0.
         rd = (rd << n) | 8'((n == 1 ? dq_i >> 1 : dq_i) & m);
         sclk_o = 1'b1;
         half();
         sclk_o = 1'b0;
      end
      half();
      cs_n_o = 1'b1;
      half();
   endtask
endmodule
